// [dms_pkg.sv]
// Purpose: Shared constants and types for the drive operation-mode selection block.
// Assumes: Mode codes are 8-bit signed object values; only 0 to 10 carry meaning.
// Notes: Object indices stand for the register addresses of the object dictionary.
// Operation
// - Mode value 1 is profile position, 3 profile velocity, 4 profile torque and 6 homing.
// - Mode value 8 is cyclic synchronous position, 9 cyclic velocity and 10 cyclic torque.
// - Values 0, 2 and 5 are reserved and value 7, interpolated position, is not supported.
// - An unsupported mode written by an acyclic service write is refused with an abort answer.
// - An unsupported mode arriving in cyclic process data is ignored and the present mode kept.
// - The read-only display object shows the mode really in effect, in the request encoding.
// - Leaving either position mode discards every position reference not yet executed.
// - Leaving a velocity or torque mode first performs a ramp stop, then enters the new mode.
// - While homing runs, any change to another mode is deferred.
// - Homing may be left once it has completed or was interrupted by a fault or servo-off.
// - 125 us and 250 us cycles suit only torque modes, 500 us adds the velocity modes, 1 ms suits all.
// - A cycle time not allowed for the active mode raises an error flag.
// - Cycle times above 1 ms are accepted when they are a whole multiple of the 250 us loop period.
// - A read-only bitmap object lists the modes, one bit per mode; its value 000003A1 sets bits for only five of the seven supported modes.
package dms_pkg;

    // ==========================================================
    // Object indices
    localparam logic [15:0] OBJ_MODE_REQUEST = 16'h6060;
    localparam logic [15:0] OBJ_MODE_DISPLAY = 16'h6061;
    localparam logic [15:0] OBJ_MODE_SUPPORT = 16'h6502;

    // ==========================================================
    // Reset values and the supported-mode bitmap
    localparam logic [7:0] MODE_REQUEST_RESET = 8'h00;
    localparam logic [7:0] MODE_DISPLAY_RESET = 8'h00;
    localparam logic [31:0] MODE_SUPPORT_MAP = 32'h000003A1;

    // ==========================================================
    // Mode codes
    localparam logic [7:0] MODE_NONE = 8'h00;
    localparam logic [7:0] PROFILE_POSITION_MODE = 8'h01;
    localparam logic [7:0] PROFILE_VELOCITY_MODE = 8'h03;
    localparam logic [7:0] PROFILE_TORQUE_MODE = 8'h04;
    localparam logic [7:0] HOMING_MODE = 8'h06;
    localparam logic [7:0] INTERPOLATED_POSITION_MODE = 8'h07;
    localparam logic [7:0] CYCLIC_SYNC_POSITION_MODE = 8'h08;
    localparam logic [7:0] CYCLIC_SYNC_VELOCITY_MODE = 8'h09;
    localparam logic [7:0] CYCLIC_SYNC_TORQUE_MODE = 8'h0A;

    // ==========================================================
    // Service abort codes
    localparam logic [31:0] ABORT_NONE = 32'h00000000;
    localparam logic [31:0] ABORT_READ_ONLY = 32'h06010002;
    localparam logic [31:0] ABORT_NO_OBJECT = 32'h06020000;
    localparam logic [31:0] ABORT_BAD_VALUE = 32'h06090030;

    // ==========================================================
    // Timing: clock, position loop and allowed cycle times in microseconds
    localparam int CLOCK_HZ = 20000000;
    localparam int LOOP_PERIOD_US = 250;
    localparam int LOOP_CYCLES = (CLOCK_HZ / 1000000) * LOOP_PERIOD_US;
    localparam logic [15:0] CYCLE_125_US = 16'd125;
    localparam logic [15:0] CYCLE_250_US = 16'd250;
    localparam logic [15:0] CYCLE_500_US = 16'd500;
    localparam logic [15:0] CYCLE_1_MS_US = 16'd1000;

    // ==========================================================
    // Switchover states
    typedef enum logic [1:0] {
        DMS_RUN,
        DMS_RAMP
    } dms_state_t;

endpackage

// [dms_mode_select.sv]
// Purpose: Operation-mode request, validation and switchover for a servo drive.
// Assumes: Service and process data ports are synchronous to clock; requests are single-cycle strobes.
// Notes: Mode changes start and the cycle-time check is evaluated on the position loop tick; a ramp stop ends on ramp_stop_done.
`timescale 1ns/100ps
module dms_mode_select
    import dms_pkg::*;
#(
    parameter int LOOP_TICK_CYCLES = LOOP_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Acyclic service data access
    input wire logic sdo_req,
    input wire logic sdo_write,
    input wire logic [15:0] sdo_index,
    input wire logic [7:0] sdo_wdata,
    output logic sdo_done,
    output logic sdo_abort,
    output logic [31:0] sdo_abort_code,
    output logic [31:0] sdo_rdata,
    // Cyclic process data
    input wire logic pdo_valid,
    input wire logic [7:0] pdo_mode,
    // Drive status
    input wire logic homing_running,
    input wire logic homing_done,
    input wire logic drive_fault,
    input wire logic servo_on,
    input wire logic ramp_stop_done,
    input wire logic [15:0] cycle_time_us,
    // Switchover results
    output logic ramp_stop_req,
    output logic discard_position_refs,
    output logic cycle_time_error,
    output logic [7:0] operation_mode_request,
    output logic [7:0] operation_mode_display,
    output logic loop_tick
);

    // ==========================================================
    // Helper functions

    // Modes this drive can run.
    function automatic logic mode_supported(input logic [7:0] m);
        case (m)
            PROFILE_POSITION_MODE, PROFILE_VELOCITY_MODE, PROFILE_TORQUE_MODE, HOMING_MODE: begin
                return 1'b1;
            end
            CYCLIC_SYNC_POSITION_MODE, CYCLIC_SYNC_VELOCITY_MODE, CYCLIC_SYNC_TORQUE_MODE: begin
                return 1'b1;
            end
            default: begin
                return 1'b0; // Reserved 0, 2, 5 and unsupported interpolated position 7.
            end
        endcase
    endfunction

    // Modes that must ramp to a stop before being left.
    function automatic logic mode_needs_ramp(input logic [7:0] m);
        return (m == PROFILE_VELOCITY_MODE) || (m == PROFILE_TORQUE_MODE) ||
               (m == CYCLIC_SYNC_VELOCITY_MODE) || (m == CYCLIC_SYNC_TORQUE_MODE);
    endfunction

    // Modes whose unexecuted position references are dropped on exit.
    function automatic logic mode_is_position(input logic [7:0] m);
        return (m == PROFILE_POSITION_MODE) || (m == CYCLIC_SYNC_POSITION_MODE);
    endfunction

    // Whether a communication cycle time is allowed for a mode.
    function automatic logic cycle_allowed(input logic [7:0] m, input logic [15:0] t);
        logic torque;
        logic velocity;
        torque = (m == PROFILE_TORQUE_MODE) || (m == CYCLIC_SYNC_TORQUE_MODE);
        velocity = (m == PROFILE_VELOCITY_MODE) || (m == CYCLIC_SYNC_VELOCITY_MODE);
        if (t == CYCLE_125_US || t == CYCLE_250_US) begin
            return torque;
        end else if (t == CYCLE_500_US) begin
            return torque || velocity;
        end else if (t == CYCLE_1_MS_US) begin
            return 1'b1;
        end else if (t > CYCLE_1_MS_US) begin
            return (t % CYCLE_250_US) == 16'd0;
        end
        return 1'b0;
    endfunction

    // ==========================================================
    // Reset release: asynchronous assert, two-flop synchronous release.
    logic rst_meta_reg;
    logic rst_sync_n_reg;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_n_reg <= rst_meta_reg;
        end
    end

    // ==========================================================
    // Block state
    typedef struct packed {
        dms_state_t state;
        logic [15:0] div_count;
        logic tick;
        logic [7:0] request;
        logic [7:0] active;
        logic ramp_req;
        logic discard;
        logic cycle_err;
        logic sdo_done;
        logic sdo_abort;
        logic [31:0] sdo_code;
        logic [31:0] sdo_rdata;
    } dms_regs_t;

    localparam logic [15:0] TICK_LAST = 16'(LOOP_TICK_CYCLES - 1);

    dms_regs_t st_reg;
    dms_regs_t st_next;

    // Next-state logic for the loop divider, object access and switchover.
    always_comb begin
        logic homing_blocks;
        homing_blocks = 1'b0;
        st_next = st_reg;
        st_next.tick = 1'b0;
        st_next.discard = 1'b0;
        st_next.sdo_done = 1'b0;
        st_next.sdo_abort = 1'b0;
        st_next.sdo_code = ABORT_NONE;

        // Position loop period divider; the tick paces switchover and the cycle check.
        if (st_reg.div_count == TICK_LAST) begin
            st_next.div_count = 16'h0000;
            st_next.tick = 1'b1;
        end else begin
            st_next.div_count = st_reg.div_count + 16'h0001;
        end

        // Cyclic mode requests: bad codes are dropped silently.
        if (pdo_valid && mode_supported(pdo_mode)) begin
            st_next.request = pdo_mode;
        end

        // Acyclic object access answers one cycle later; a service write wins over process data.
        if (sdo_req) begin
            st_next.sdo_done = 1'b1;
            st_next.sdo_rdata = 32'h00000000;
            case (sdo_index)
                OBJ_MODE_REQUEST: begin
                    if (!sdo_write) begin
                        st_next.sdo_rdata = {24'h000000, st_reg.request};
                    end else if (mode_supported(sdo_wdata)) begin
                        st_next.request = sdo_wdata;
                    end else begin
                        st_next.sdo_abort = 1'b1;
                        st_next.sdo_code = ABORT_BAD_VALUE;
                    end
                end
                OBJ_MODE_DISPLAY: begin
                    if (sdo_write) begin
                        st_next.sdo_abort = 1'b1;
                        st_next.sdo_code = ABORT_READ_ONLY;
                    end else begin
                        st_next.sdo_rdata = {24'h000000, st_reg.active};
                    end
                end
                OBJ_MODE_SUPPORT: begin
                    if (sdo_write) begin
                        st_next.sdo_abort = 1'b1;
                        st_next.sdo_code = ABORT_READ_ONLY;
                    end else begin
                        st_next.sdo_rdata = MODE_SUPPORT_MAP;
                    end
                end
                default: begin
                    st_next.sdo_abort = 1'b1;
                    st_next.sdo_code = ABORT_NO_OBJECT;
                end
            endcase
        end

        // Homing holds the mode until it ends, faults or loses servo-on.
        homing_blocks = (st_reg.active == HOMING_MODE) && homing_running &&
                        !(homing_done || drive_fault || !servo_on);

        // Switchover sequencing: a switch starts on a loop tick; a ramp stop ends on ramp_stop_done in any cycle.
        case (st_reg.state)
            DMS_RUN: begin
                if (st_reg.tick && st_reg.request != st_reg.active && !homing_blocks) begin
                    if (mode_needs_ramp(st_reg.active)) begin
                        st_next.state = DMS_RAMP;
                        st_next.ramp_req = 1'b1;
                    end else begin
                        st_next.discard = mode_is_position(st_reg.active);
                        st_next.active = st_reg.request;
                    end
                end
            end
            DMS_RAMP: begin
                // The target is taken when the ramp ends, so a later request still counts.
                if (ramp_stop_done) begin
                    st_next.ramp_req = 1'b0;
                    st_next.state = DMS_RUN;
                    st_next.active = st_reg.request;
                end
            end
            default: begin
                st_next.state = DMS_RUN;
                st_next.ramp_req = 1'b0;
            end
        endcase

        // Cycle time check against the mode in effect; no mode selected means nothing to check.
        if (st_reg.tick) begin
            st_next.cycle_err = (st_reg.active != MODE_NONE) &&
                                !cycle_allowed(st_reg.active, cycle_time_us);
        end
    end

    // State register.
    always_ff @(posedge clock or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            st_reg.state <= DMS_RUN;
            st_reg.div_count <= 16'h0000;
            st_reg.tick <= 1'b0;
            st_reg.request <= MODE_REQUEST_RESET;
            st_reg.active <= MODE_DISPLAY_RESET;
            st_reg.ramp_req <= 1'b0;
            st_reg.discard <= 1'b0;
            st_reg.cycle_err <= 1'b0;
            st_reg.sdo_done <= 1'b0;
            st_reg.sdo_abort <= 1'b0;
            st_reg.sdo_code <= ABORT_NONE;
            st_reg.sdo_rdata <= 32'h00000000;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Outputs, all straight from the state register.
    assign sdo_done = st_reg.sdo_done;
    assign sdo_abort = st_reg.sdo_abort;
    assign sdo_abort_code = st_reg.sdo_code;
    assign sdo_rdata = st_reg.sdo_rdata;
    assign ramp_stop_req = st_reg.ramp_req;
    assign discard_position_refs = st_reg.discard;
    assign cycle_time_error = st_reg.cycle_err;
    assign operation_mode_request = st_reg.request;
    assign operation_mode_display = st_reg.active;
    assign loop_tick = st_reg.tick;

endmodule // dms_mode_select

// [dms_host_model.sv]
// Purpose: Host controller model that sends mode codes in cyclic data.
// Assumes: Called from the bench, shortly after a rising clock edge.
// Notes: The mode line shows the inverse of the last code outside a frame.
`timescale 1ns/100ps
module dms_host_model #(
    parameter int GAP = 8
) (
    // Clock.
    input wire logic clock,
    // Cyclic data to the drive.
    output logic pdo_valid,
    output logic [7:0] pdo_mode
);
    int since = GAP;

    // Count cycles since the last reference frame.
    // The counter restarts on the edge that takes a frame, so it has a single driver.
    always @(posedge clock) begin
        since <= pdo_valid ? 0 : since + 1;
    end

    initial begin
        pdo_valid = 1'b0;
        pdo_mode = 8'hFF;
    end

    // Frames keep a minimum spacing, so no reference is lost.
    task automatic send(input logic [7:0] code);
        while (since < GAP) @(posedge clock);
        #2;
        pdo_valid = 1'b1;
        pdo_mode = code;
        @(posedge clock);
        #2;
        pdo_valid = 1'b0;
        pdo_mode = ~code;
    endtask
endmodule // dms_host_model

// [dms_mode_select_sva.sv]
// Purpose: Port assertions for the mode select block.
// Assumes: Requests start once the internal reset has left.
// Notes: Attached by bind to every instance.
`timescale 1ns/100ps
module dms_mode_select_chk
    import dms_pkg::*;
(
    // Watched ports.
    input wire logic clock, resetn, sdo_req, sdo_write, sdo_done, pdo_valid,
    input wire logic homing_running, homing_done, drive_fault, servo_on,
    input wire logic ramp_stop_done, ramp_stop_req, discard_position_refs,
    input wire logic cycle_time_error, loop_tick,
    input wire logic [15:0] sdo_index, cycle_time_us,
    input wire logic [7:0] sdo_wdata, pdo_mode,
    input wire logic [7:0] operation_mode_request, operation_mode_display,
    input wire logic [31:0] sdo_abort_code
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    logic w_ok, p_ok, chg;

    // Supported codes, and a pending switch.
    assign w_ok = sdo_wdata inside {8'h01, 8'h03, 8'h04, 8'h06, 8'h08, 8'h09, 8'h0A};
    assign p_ok = pdo_mode inside {8'h01, 8'h03, 8'h04, 8'h06, 8'h08, 8'h09, 8'h0A};
    assign chg = loop_tick && operation_mode_request != operation_mode_display;

    sdo_answer_a: assert property (sdo_req |=> sdo_done) else $error("no service answer");
    bad_mode_a: assert property (sdo_req && sdo_write && sdo_index == OBJ_MODE_REQUEST && !w_ok
        |=> sdo_abort_code == ABORT_BAD_VALUE && $stable(operation_mode_request)) else $error("bad mode taken");
    pdo_drop_a: assert property (pdo_valid && !p_ok && !sdo_req
        |=> $stable(operation_mode_request)) else $error("bad cyclic mode taken");
    pdo_take_a: assert property (pdo_valid && p_ok && !sdo_req
        |=> operation_mode_request == $past(pdo_mode)) else $error("cyclic mode lost");
    pos_discard_a: assert property (chg && operation_mode_display inside {8'h01, 8'h08}
        |=> discard_position_refs && operation_mode_display == $past(operation_mode_request))
        else $error("references kept");
    ramp_start_a: assert property (chg && !ramp_stop_req
        && operation_mode_display inside {8'h03, 8'h04, 8'h09, 8'h0A}
        |=> ramp_stop_req && $stable(operation_mode_display)) else $error("no ramp stop");
    ramp_end_a: assert property (ramp_stop_req && ramp_stop_done
        |=> !ramp_stop_req && operation_mode_display == $past(operation_mode_request))
        else $error("ramp end wrong");
    homing_hold_a: assert property (loop_tick && operation_mode_display == HOMING_MODE && homing_running
        && !homing_done && !drive_fault && servo_on |=> $stable(operation_mode_display)) else $error("homing left");
    cycle_flag_a: assert property (loop_tick && operation_mode_display == PROFILE_POSITION_MODE
        && cycle_time_us == CYCLE_500_US |=> cycle_time_error) else $error("cycle error missed");
endmodule // dms_mode_select_chk

bind dms_mode_select dms_mode_select_chk u_chk (
    .clock(clock), .resetn(resetn), .sdo_req(sdo_req), .sdo_write(sdo_write), .sdo_done(sdo_done),
    .pdo_valid(pdo_valid), .homing_running(homing_running), .homing_done(homing_done),
    .drive_fault(drive_fault), .servo_on(servo_on), .ramp_stop_done(ramp_stop_done),
    .ramp_stop_req(ramp_stop_req), .discard_position_refs(discard_position_refs),
    .cycle_time_error(cycle_time_error), .loop_tick(loop_tick), .sdo_index(sdo_index),
    .cycle_time_us(cycle_time_us), .sdo_wdata(sdo_wdata), .pdo_mode(pdo_mode),
    .operation_mode_request(operation_mode_request), .operation_mode_display(operation_mode_display),
    .sdo_abort_code(sdo_abort_code)
);

// [tb_drive_mode_select_switchover.sv]
// Purpose: Self-checking bench for mode select and switchover.
// Assumes: Loop tick shortened to 8 cycles.
// Notes: Inputs change 2 ns after the rising edge.
`timescale 1ns/100ps
module tb_drive_mode_select_switchover;
    import dms_pkg::*;
    logic clock = 0, resetn = 0, sdo_req = 0, sdo_write = 0, servo_on = 1;
    logic homing_running = 0, homing_done = 0, drive_fault = 0, ramp_stop_done = 0;
    logic [15:0] sdo_index = 16'h0000, cycle_time_us = 16'h03E8;
    logic [7:0] sdo_wdata = 8'h00;
    logic sdo_done, sdo_abort, pdo_valid, ramp_stop_req, discard_position_refs, cycle_time_error, loop_tick;
    logic [31:0] sdo_abort_code, sdo_rdata;
    logic [7:0] pdo_mode, operation_mode_request, operation_mode_display;
    logic [31:0] tbl [7] = '{32'h04007D00, 32'h0901F400, 32'h0101F401, 32'h01044C01,
        32'h0104E200, 32'h0A00FA00, 32'h0300FA01};
    int n_mismatch = 0, checks_done = 0;

    always #25 clock = ~clock;
    dms_mode_select #(.LOOP_TICK_CYCLES(8)) u_dut (
        .clock(clock), .resetn(resetn), .sdo_req(sdo_req), .sdo_write(sdo_write), .sdo_index(sdo_index),
        .sdo_wdata(sdo_wdata), .sdo_done(sdo_done), .sdo_abort(sdo_abort), .sdo_abort_code(sdo_abort_code),
        .sdo_rdata(sdo_rdata), .pdo_valid(pdo_valid), .pdo_mode(pdo_mode), .homing_running(homing_running),
        .homing_done(homing_done), .drive_fault(drive_fault), .servo_on(servo_on),
        .ramp_stop_done(ramp_stop_done), .cycle_time_us(cycle_time_us), .ramp_stop_req(ramp_stop_req),
        .discard_position_refs(discard_position_refs), .cycle_time_error(cycle_time_error),
        .operation_mode_request(operation_mode_request), .operation_mode_display(operation_mode_display),
        .loop_tick(loop_tick)
    );
    dms_host_model u_host (.clock(clock), .pdo_valid(pdo_valid), .pdo_mode(pdo_mode));

    task automatic chk(input string name, input logic [31:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One service access; the answer stands for one cycle only.
    task automatic sdo(input logic wr, input logic [15:0] idx, input logic [7:0] wd, input logic [31:0] code);
        @(posedge clock);
        #2;
        sdo_req = 1;
        sdo_write = wr;
        sdo_index = idx;
        sdo_wdata = wd;
        @(posedge clock);
        #2;
        sdo_req = 0;
        chk("sdo_done", 32'h1, sdo_done);
        chk("sdo_abort", {31'h0, code != ABORT_NONE}, {31'h0, sdo_abort});
        chk("sdo_abort_code", code, sdo_abort_code);
    endtask

    // Counts loop ticks, ending in the cycle after the last one.
    task automatic tick(input int n);
        for (int i = 0; i < 100 && n > 0; i++) begin
            if (loop_tick === 1'b1) n--;
            @(posedge clock);
            #2;
        end
    endtask

    // Requests a mode and finishes any ramp stop on the way.
    task automatic settle(input logic [7:0] m);
        sdo(1'b1, OBJ_MODE_REQUEST, m, ABORT_NONE);
        for (int i = 0; i < 60 && operation_mode_display !== m; i++) begin
            @(posedge clock);
            #2;
            ramp_stop_done = ramp_stop_req;
        end
        ramp_stop_done = 0;
        chk("display", {24'h0, m}, {24'h0, operation_mode_display});
    endtask

    task automatic t_reset;
        int n;
        chk("display", 32'h0, {24'h0, operation_mode_display});
        chk("request", 32'h0, {24'h0, operation_mode_request});
        sdo(1'b0, OBJ_MODE_SUPPORT, 8'h00, ABORT_NONE);
        chk("support", 32'h000003A1, sdo_rdata);
        // The loop tick must come every eight cycles with the shortened divider.
        tick(1);
        for (n = 1; n < 20 && loop_tick !== 1'b1; n++) begin
            @(posedge clock);
            #2;
        end
        chk("tick period", 32'd8, 32'(n));
    endtask

    task automatic t_codes;
        logic [7:0] old;
        for (int c = 0; c < 11; c++) begin
            old = operation_mode_request;
            if (c inside {1, 3, 4, 6, 8, 9, 10}) begin
                sdo(1'b1, OBJ_MODE_REQUEST, 8'(c), ABORT_NONE);
                chk("request", 32'(c), {24'h0, operation_mode_request});
            end else begin
                sdo(1'b1, OBJ_MODE_REQUEST, 8'(c), ABORT_BAD_VALUE);
                chk("request", {24'h0, old}, {24'h0, operation_mode_request});
            end
        end
        sdo(1'b1, OBJ_MODE_DISPLAY, 8'h01, ABORT_READ_ONLY);
        sdo(1'b1, OBJ_MODE_SUPPORT, 8'h01, ABORT_READ_ONLY);
        sdo(1'b1, 16'h1234, 8'h01, ABORT_NO_OBJECT);
    endtask

    task automatic t_pdo;
        settle(PROFILE_POSITION_MODE);
        u_host.send(INTERPOLATED_POSITION_MODE);
        chk("request", 32'h1, {24'h0, operation_mode_request});
        u_host.send(CYCLIC_SYNC_POSITION_MODE);
        tick(1);
        chk("discard", 32'h1, {31'h0, discard_position_refs});
        chk("display", 32'h8, {24'h0, operation_mode_display});
        sdo(1'b0, OBJ_MODE_DISPLAY, 8'h00, ABORT_NONE);
        chk("display object", 32'h8, sdo_rdata);
        sdo(1'b0, OBJ_MODE_REQUEST, 8'h00, ABORT_NONE);
        chk("request object", 32'h8, sdo_rdata);
    endtask

    task automatic t_ramp;
        settle(CYCLIC_SYNC_VELOCITY_MODE);
        sdo(1'b1, OBJ_MODE_REQUEST, PROFILE_TORQUE_MODE, ABORT_NONE);
        tick(1);
        chk("ramp_stop_req", 32'h1, {31'h0, ramp_stop_req});
        repeat (3) @(posedge clock);
        #2;
        chk("display", 32'h9, {24'h0, operation_mode_display});
        ramp_stop_done = 1;
        @(posedge clock);
        #2;
        ramp_stop_done = 0;
        chk("display", 32'h4, {24'h0, operation_mode_display});
        chk("ramp_stop_req", 32'h0, {31'h0, ramp_stop_req});
    endtask

    task automatic t_cycle;
        for (int k = 0; k < 7; k++) begin
            settle(tbl[k][31:24]);
            cycle_time_us = tbl[k][23:8];
            tick(2);
            chk("cycle_time_error", {31'h0, tbl[k][0]}, {31'h0, cycle_time_error});
        end
        cycle_time_us = 16'h03E8;
    endtask

    task automatic t_homing;
        for (int k = 0; k < 3; k++) begin
            homing_running = 0;
            settle(HOMING_MODE);
            homing_running = 1;
            sdo(1'b1, OBJ_MODE_REQUEST, PROFILE_VELOCITY_MODE, ABORT_NONE);
            tick(2);
            chk("display", 32'h6, {24'h0, operation_mode_display});
            homing_done = (k == 0);
            drive_fault = (k == 1);
            servo_on = (k != 2);
            tick(1);
            chk("display", 32'h3, {24'h0, operation_mode_display});
            homing_done = 0;
            drive_fault = 0;
            servo_on = 1;
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence, after four cycles of reset.
    initial begin
        repeat (4) @(posedge clock);
        #2;
        resetn = 1;
        repeat (3) @(posedge clock);
        #2;
        t_reset();
        t_codes();
        t_pdo();
        t_ramp();
        t_cycle();
        t_homing();
        end_sim();
    end

    // The run needs about 330 cycles; this cuts a hang short.
    initial begin
        #400000;
        n_mismatch++;
        end_sim();
    end
endmodule // tb_drive_mode_select_switchover
